//--- design/itsg_intertrip.sv
// Intertrip and permissive intertrip signalling logic.
`timescale 1ns/1ps
`include "itsg_consts.svh"

// Contract
// - Filtered direct initiate sets transmitted direct bit
// - Direct initiate gives no local trip
// - Confirmed direct bit drives separate intertrip contacts
// - Direct output needs no current interlock
// - Initiate pickup three samples, dropout one
// - Received bit valid after two messages
// - Intertrip output held at least 60 ms
// - Permissive initiate sets bit, no local trip
// - Permissive trip needs current over delay
// - Permissive trip drives shared three-phase trip
// - Permissive uses same filter and confirmation
// - Two block-autoreclose contacts on permissive trip
module itsg_intertrip
  import itsg_pkg::*;
#(
  parameter int SAMPLE_CYC = `ITSG_SAMPLE_CYC,
  parameter int HOLD_SAMP  = `ITSG_HOLD_SAMPLES,
  parameter int W          = 16
) (
  input  wire logic         MCLK,
  input  wire logic         RST_B,
  input  wire logic         DIRECT_INIT,
  input  wire logic         PERM_INIT,
  input  wire logic         RX_VALID,
  input  wire itsg_status_s RX_STATUS,
  input  wire logic [W-1:0] REMOTE_CURRENT,
  input  wire logic         DIFF_TRIP,
  input  wire logic [1:0]   ADDR,
  input  wire logic [W-1:0] WDATA,
  input  wire logic         WR,
  input  wire logic         RD,
  output logic      [W-1:0] RDATA,
  output itsg_status_s      TX_STATUS,
  output logic              SAMPLE_TICK,
  output logic [3:0]        INTERTRIP_OUT,
  output logic [2:0]        TRIP_OUT,
  output logic [1:0]        BLOCK_AR
);

  // ****************************************************************
  // Sample tick divider
  // ****************************************************************
  localparam int TW = $clog2(SAMPLE_CYC + 1);
  logic [TW-1:0] div_reg;
  logic          tick;

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      div_reg <= '0;
    end else if (div_reg == TW'(SAMPLE_CYC - 1)) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + TW'(1);
    end
  end
  assign tick = (div_reg == TW'(SAMPLE_CYC - 1));
  assign SAMPLE_TICK = tick;

  // ****************************************************************
  // Initiate input filters
  // ****************************************************************
  // Pickup needs a run of active samples; one inactive sample drops out.
  function automatic logic [1:0] pickup_next(input logic [1:0] cnt, input logic lvl);
    if (!lvl) begin
      pickup_next = 2'h0;
    end else if (cnt < 2'(`ITSG_PICKUP_SAMPLES)) begin
      pickup_next = cnt + 2'h1;
    end else begin
      pickup_next = cnt;
    end
  endfunction : pickup_next

  logic [1:0] dcnt_reg;
  logic [1:0] pcnt_reg;

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      dcnt_reg <= 2'h0;
      pcnt_reg <= 2'h0;
    end else if (tick) begin
      dcnt_reg <= pickup_next(dcnt_reg, DIRECT_INIT);
      pcnt_reg <= pickup_next(pcnt_reg, PERM_INIT);
    end
  end

  // The filtered levels go to the message and the status word; nothing local trips on them.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      TX_STATUS <= '0;
    end else begin
      TX_STATUS.direct     <= (dcnt_reg == 2'(`ITSG_PICKUP_SAMPLES));
      TX_STATUS.permissive <= (pcnt_reg == 2'(`ITSG_PICKUP_SAMPLES));
    end
  end

  // ****************************************************************
  // Received bit confirmation
  // ****************************************************************
  // Messages arriving between ticks are latched and judged on the next tick.
  itsg_status_s last_reg;
  itsg_status_s conf_reg;
  itsg_status_s pend_reg;
  logic         pend_v_reg;

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      pend_reg   <= '0;
      pend_v_reg <= 1'b0;
    end else if (RX_VALID) begin
      pend_reg   <= RX_STATUS;
      pend_v_reg <= 1'b1;
    end else if (tick) begin
      pend_v_reg <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      last_reg <= '0;
      conf_reg <= '0;
    end else if (tick && pend_v_reg) begin
      last_reg <= pend_reg;
      conf_reg <= pend_reg & last_reg;
    end
  end

  // ****************************************************************
  // Direct intertrip output hold
  // ****************************************************************
  localparam int HW = $clog2(HOLD_SAMP + 1);
  logic [HW-1:0] hold_reg;
  logic          it_reg;

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      hold_reg <= '0;
    end else if (tick) begin
      if (conf_reg.direct && !it_reg) begin
        hold_reg <= HW'(HOLD_SAMP);
      end else if (hold_reg != '0) begin
        hold_reg <= hold_reg - HW'(1);
      end
    end
  end

  // No current check here: the received bit alone closes the contacts.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      it_reg <= 1'b0;
    end else if (tick) begin
      it_reg <= conf_reg.direct || (hold_reg > HW'(1));
    end
  end
  assign INTERTRIP_OUT = {4{it_reg}};

  // ****************************************************************
  // Settings
  // ****************************************************************
  logic [W-1:0] threshold;
  logic [W-1:0] pdelay;
  logic [W-1:0] status_word;

  itsg_settings #(
    .W (W)
  ) u_settings (
    .clk         (MCLK),
    .rst_b       (RST_B),
    .addr        (ADDR),
    .wdata       (WDATA),
    .wr          (WR),
    .rd          (RD),
    .status_word (status_word),
    .rdata       (RDATA),
    .threshold   (threshold),
    .delay       (pdelay)
  );

  // ****************************************************************
  // Permissive trip timer
  // ****************************************************************
  itsg_ptrip_e  pst_reg;
  logic [W-1:0] ptim_reg;
  logic         over;

  assign over = (REMOTE_CURRENT > threshold);

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      pst_reg  <= ITSG_PT_IDLE;
      ptim_reg <= '0;
    end else if (tick) begin
      case (pst_reg)
        ITSG_PT_IDLE: begin
          ptim_reg <= '0;
          if (conf_reg.permissive && over) pst_reg <= ITSG_PT_TIMING;
        end
        ITSG_PT_TIMING: begin
          if (!conf_reg.permissive || !over) begin
            pst_reg <= ITSG_PT_IDLE;
          end else if (ptim_reg >= pdelay) begin
            pst_reg <= ITSG_PT_TRIPPED;
          end else begin
            ptim_reg <= ptim_reg + W'(1);
          end
        end
        ITSG_PT_TRIPPED: begin
          if (!conf_reg.permissive || !over) pst_reg <= ITSG_PT_IDLE;
        end
        default: pst_reg <= ITSG_PT_IDLE;
      endcase
    end
  end

  // Shared with differential protection; all three phases together.
  logic ptrip;
  assign ptrip = (pst_reg == ITSG_PT_TRIPPED);

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      TRIP_OUT <= 3'h0;
      BLOCK_AR <= 2'h0;
    end else begin
      TRIP_OUT <= {3{ptrip || DIFF_TRIP}};
      BLOCK_AR <= {2{ptrip}};
    end
  end

  assign status_word = W'({ptrip, it_reg, conf_reg.permissive, conf_reg.direct,
                           TX_STATUS.permissive, TX_STATUS.direct});

endmodule : itsg_intertrip

//--- design/itsg_consts.svh
// Timing counts, field positions and reset values for the intertrip signalling block.
`ifndef ITSG_CONSTS_SVH
`define ITSG_CONSTS_SVH

// ****************************************************************
// Clock and sample timing
// ****************************************************************
`define ITSG_CLK_HZ            50000000
`define ITSG_SAMPLE_US         1250
`define ITSG_SAMPLE_CYC        ((`ITSG_CLK_HZ / 1000000) * `ITSG_SAMPLE_US)
`define ITSG_HOLD_MS           60
`define ITSG_HOLD_SAMPLES      ((`ITSG_HOLD_MS * 1000 + `ITSG_SAMPLE_US - 1) / `ITSG_SAMPLE_US)

// ****************************************************************
// Filter and confirmation counts
// ****************************************************************
`define ITSG_PICKUP_SAMPLES    3
`define ITSG_CONFIRM_MSGS      2

// ****************************************************************
// Status field positions in the exchanged message
// ****************************************************************
`define ITSG_BIT_DIRECT        0
`define ITSG_BIT_PERMISSIVE    1

// ****************************************************************
// Reset values of software settings
// ****************************************************************
`define ITSG_RST_THRESHOLD     16'h0000
`define ITSG_RST_DELAY         16'h0010

`endif

//--- design/itsg_pkg.sv
// Types shared by the intertrip signalling block.
package itsg_pkg;
  typedef struct packed {
    logic permissive;
    logic direct;
  } itsg_status_s;

  typedef enum logic [1:0] {
    ITSG_PT_IDLE,
    ITSG_PT_TIMING,
    ITSG_PT_TRIPPED
  } itsg_ptrip_e;
endpackage : itsg_pkg

//--- design/itsg_settings.sv
// Setting store for the current threshold and permissive delay.
`timescale 1ns/1ps
`include "itsg_consts.svh"
module itsg_settings
  import itsg_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [1:0]   addr,
  input  wire logic [W-1:0] wdata,
  input  wire logic         wr,
  input  wire logic         rd,
  input  wire logic [W-1:0] status_word,
  output logic      [W-1:0] rdata,
  output logic      [W-1:0] threshold,
  output logic      [W-1:0] delay
);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      threshold <= `ITSG_RST_THRESHOLD;
      delay     <= `ITSG_RST_DELAY;
    end else if (wr) begin
      if (addr == 2'h0) threshold <= wdata;
      if (addr == 2'h1) delay     <= wdata;
    end
  end

  // Unmapped addresses read zero.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        2'h0:    rdata <= threshold;
        2'h1:    rdata <= delay;
        2'h2:    rdata <= status_word;
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end
endmodule : itsg_settings

//--- sim/itsg_remote.sv
// Remote relay model that sends one status message every GAP clocks.
`timescale 1ns/1ps
module itsg_remote
  import itsg_pkg::*;
#(parameter int GAP = 10) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire itsg_status_s st,
  output logic              vld,
  output itsg_status_s      rx
);
  int c;
  // Between messages the lines toggle, so a stale status can never pass for a fresh one.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      c <= 0;
      vld <= 1'b0;
      rx <= '0;
    end else begin
      c <= (c == GAP - 1) ? 0 : c + 1;
      vld <= (c == GAP - 1);
      rx <= (c == GAP - 1) ? st : ~rx;
    end
  end
endmodule : itsg_remote

//--- sim/itsg_intertrip_asserts.sv
// Port checks for the intertrip block.
`timescale 1ns/1ps
module itsg_intertrip_asserts
  import itsg_pkg::*;
#(parameter int SAMPLE_CYC = 10, parameter int HOLD_SAMP = 4) (
  input wire logic         MCLK,
  input wire logic         RST_B,
  input wire logic         DIRECT_INIT,
  input wire logic         PERM_INIT,
  input wire logic         DIFF_TRIP,
  input wire itsg_status_s TX_STATUS,
  input wire logic         SAMPLE_TICK,
  input wire logic [3:0]   INTERTRIP_OUT,
  input wire logic [2:0]   TRIP_OUT,
  input wire logic [1:0]   BLOCK_AR
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  int hcnt;
  // Counts clocks of closed intertrip contacts to bound the minimum hold.
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) hcnt <= 0;
    else hcnt <= INTERTRIP_OUT[0] ? hcnt + 1 : 0;
  end
  property p_per; SAMPLE_TICK |-> ##SAMPLE_CYC SAMPLE_TICK; endproperty
  a_per: assert property (p_per) else $error("tick period");
  // The filter counter moves on the tick edge and the status bit one clock later.
  property p_rise; $rose(TX_STATUS.direct) |-> $past(SAMPLE_TICK, 2) && $past(DIRECT_INIT, 2)
    && $past(DIRECT_INIT, SAMPLE_CYC + 2) && $past(DIRECT_INIT, 2 * SAMPLE_CYC + 2); endproperty
  a_rise: assert property (p_rise) else $error("pickup");
  property p_drop; SAMPLE_TICK && !PERM_INIT |-> ##2 !TX_STATUS.permissive; endproperty
  a_drop: assert property (p_drop) else $error("dropout");
  property p_all; INTERTRIP_OUT != 4'h0 |-> INTERTRIP_OUT == 4'hF; endproperty
  a_all: assert property (p_all) else $error("contacts split");
  property p_hold; $fell(INTERTRIP_OUT[0]) |-> hcnt >= (HOLD_SAMP - 1) * SAMPLE_CYC; endproperty
  a_hold: assert property (p_hold) else $error("hold short");
  property p_loc; TRIP_OUT != 3'h0 |-> $past(DIFF_TRIP) || BLOCK_AR == 2'h3; endproperty
  a_loc: assert property (p_loc) else $error("local trip");
  property p_diff; $past(DIFF_TRIP) |-> TRIP_OUT == 3'h7; endproperty
  a_diff: assert property (p_diff) else $error("diff trip");
  property p_bar; BLOCK_AR != 2'h0 |-> BLOCK_AR == 2'h3 && TRIP_OUT == 3'h7; endproperty
  a_bar: assert property (p_bar) else $error("block pair");
  c_it: cover property ($rose(INTERTRIP_OUT[0]));
  c_bar: cover property ($rose(BLOCK_AR[0]));
  c_tx: cover property ($rose(TX_STATUS.direct));
endmodule : itsg_intertrip_asserts

bind itsg_intertrip itsg_intertrip_asserts #(.SAMPLE_CYC(SAMPLE_CYC), .HOLD_SAMP(HOLD_SAMP))
  u_itsg_intertrip_asserts (.MCLK, .RST_B, .DIRECT_INIT, .PERM_INIT, .DIFF_TRIP, .TX_STATUS,
  .SAMPLE_TICK, .INTERTRIP_OUT, .TRIP_OUT, .BLOCK_AR);

//--- sim/tb_itsg_intertrip.sv
// Self-checking bench for the intertrip signalling block.
`timescale 1ns/1ps
module tb_itsg_intertrip;
  import itsg_pkg::*;
  logic         MCLK = 0, RST_B = 0, WR = 0, RD = 0, DIFF_TRIP = 0, RX_VALID, SAMPLE_TICK;
  logic [1:0]   ini = 0, ADDR = 0, BLOCK_AR;
  logic [15:0]  WDATA = 0, REMOTE_CURRENT = 0, RDATA, th;
  logic [3:0]   INTERTRIP_OUT;
  logic [2:0]   TRIP_OUT;
  itsg_status_s st = '0, RX_STATUS, TX_STATUS;
  logic [9:0]   pat = 10'h37B;
  int           err_total = 0, n_checks = 0, cnt;
  itsg_intertrip #(.SAMPLE_CYC(10), .HOLD_SAMP(4)) u_itsg_intertrip (.MCLK, .RST_B,
    .DIRECT_INIT(ini[0]), .PERM_INIT(ini[1]), .RX_VALID, .RX_STATUS, .REMOTE_CURRENT,
    .DIFF_TRIP, .ADDR, .WDATA, .WR, .RD, .RDATA, .TX_STATUS, .SAMPLE_TICK, .INTERTRIP_OUT,
    .TRIP_OUT, .BLOCK_AR);
  itsg_remote u_itsg_remote (.clk(MCLK), .rst_b(RST_B), .st, .vld(RX_VALID), .rx(RX_STATUS));
  initial forever #10 MCLK = ~MCLK;
  task automatic results;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Returns on the edge that samples the next tick, so drives land between ticks.
  task automatic tk(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(negedge MCLK);
        k++;
      end while (!SAMPLE_TICK && k < 40);
      if (k >= 40) begin
        err_total++;
        results();
      end
      @(posedge MCLK);
    end
  endtask : tk
  task automatic settle;
    @(posedge MCLK);
    @(negedge MCLK);
  endtask : settle
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge MCLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [15:0] e);
    @(posedge MCLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge MCLK);
    RD <= 1'b0;
    @(negedge MCLK);
    chk("rdata", e, RDATA);
  endtask : rd
  initial begin
    void'($urandom(64040));
    repeat (20) @(posedge MCLK);
    RST_B <= 1'b1;
    rd(2'h0, 16'h0000);
    rd(2'h1, 16'h0010);
    th = 16'($urandom & 32'h0FFF);
    wr(2'h0, th);
    wr(2'h1, 16'h0003);
    wr(2'h3, 16'hFFFF);
    rd(2'h0, th);
    rd(2'h3, 16'h0000);
    // Integer model of the pickup filter, run on both initiate inputs.
    for (int b = 0; b < 2; b++) begin
      cnt = 0;
      for (int i = 0; i < 10; i++) begin
        @(posedge MCLK);
        ini[b] <= pat[i];
        tk(1);
        settle();
        cnt = pat[i] ? cnt + 1 : 0;
        chk("tx", {15'h0, cnt >= 3}, {15'h0, TX_STATUS[b]});
        chk("trip", 16'h0, {13'h0, TRIP_OUT});
      end
      @(posedge MCLK);
      ini[b] <= 1'b0;
      tk(1);
    end
    st <= 2'b01;
    tk(1);
    st <= 2'b00;
    tk(4);
    settle();
    chk("one msg", 16'h0, {12'h0, INTERTRIP_OUT});
    @(posedge MCLK);
    st <= 2'b01;
    tk(2);
    st <= 2'b00;
    tk(3);
    settle();
    chk("intertrip", 16'h000F, {12'h0, INTERTRIP_OUT});
    chk("no trip", 16'h0, {13'h0, TRIP_OUT});
    tk(8);
    settle();
    chk("released", 16'h0, {12'h0, INTERTRIP_OUT});
    @(posedge MCLK);
    st <= 2'b10;
    REMOTE_CURRENT <= th;
    tk(10);
    settle();
    chk("at thr", 16'h0, {13'h0, TRIP_OUT});
    @(posedge MCLK);
    REMOTE_CURRENT <= th + 16'h0001;
    tk(2);
    settle();
    chk("early", 16'h0, {13'h0, TRIP_OUT});
    tk(4);
    settle();
    chk("ptrip", 16'h0007, {13'h0, TRIP_OUT});
    chk("block", 16'h0003, {14'h0, BLOCK_AR});
    rd(2'h2, 16'h0028);
    @(posedge MCLK);
    REMOTE_CURRENT <= th;
    st <= 2'b00;
    tk(2);
    settle();
    chk("dropped", 16'h0, {13'h0, TRIP_OUT});
    @(posedge MCLK);
    DIFF_TRIP <= 1'b1;
    settle();
    chk("diff", 16'h0007, {13'h0, TRIP_OUT});
    @(posedge MCLK);
    DIFF_TRIP <= 1'b0;
    results();
  end
endmodule : tb_itsg_intertrip
